// ===== nesc_pkg.sv
// Constants, register map and state codes for the neutral earth switch
// control, shared by the top and its mismatch timer.
// Assumes a single 50 MHz clock and a millisecond tick from the top.
`default_nettype none

package nesc_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int TICK_DEFAULT  = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] LEAD_MS      = 16'h0032;
    localparam logic [15:0] TIMEOUT_RST  = 16'h03E8;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;

    // ****************************************************************
    // Register map (byte addresses) and fields
    // ****************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_TIMEOUT = 8'h04;
    localparam logic [7:0] REG_IDENT   = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    localparam logic [7:0] REG_ACK     = 8'h10;
    localparam int CTRL_COMPLETE = 0;
    localparam int CTRL_SHARED   = 1;
    localparam int CTRL_COIL_AUX = 2;
    localparam int CTRL_ESCALATE = 3;
    localparam int CTRL_FB_EN    = 4;
    localparam int CTRL_W        = 5;
    localparam logic [4:0]  CTRL_RST  = 5'h00;
    localparam logic [15:0] POWER_RST = 16'h0064;
    localparam logic [7:0]  ADDR_RST  = 8'h01;
    localparam int ACK_BIT     = 0;
    localparam int NUM_PEERS   = 7;
    localparam int POWER_W     = 16;
    localparam int ADDR_W      = 8;
    localparam int RANK_W      = 2 + POWER_W + ADDR_W;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

    // ****************************************************************
    // Breaker close sequence states
    // ****************************************************************
    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'h1,
        SEQ_LEAD  = 3'h2,
        SEQ_CLOSE = 3'h4
    } nesc_seq_t;
endpackage

`default_nettype wire

// ===== nesc_top.sv
// Neutral earth switch control: drives the earthing contactor command,
// watches its feedback, arbitrates the closer among peer units, and
// holds its settings in an AHB-Lite register slave.
// Assumes peer data arrive already decoded from the power management bus.
//
// Operation
// - Simplified: close while running with voltage and frequency good.
// - Simplified: open at once in mains parallel, reclose when it ends.
// - Simplified scheme: open as soon as the stop sequence begins.
// - With feedback on in the complete scheme, raise fail warnings after the set timeout.
// - A setting escalates fail-to-close into an alarm output.
// - Topology bit: 0 per-generator switches, 1 one shared bar switch.
// - Shared: close with breaker closed, open during mains parallel.
// - Shared: no fail-to-close warning while no breaker is closed.
// - Shared: first closer commands the switch shortly before its breaker.
// - Shared: all units open but feedback closed gives fail-to-open.
// - Shared: commanding units with a breaker closed flag fail-to-close.
// - Coil supply bit chooses generator or auxiliary powered coil.
// - Per-generator, breaker open: open if stopped, or out of tolerance with a generator powered coil.
// - Per-generator, breaker closed: open in mains parallel.
// - Per-generator, breaker closed: open when a better closed-switch peer is paralleled.
// - Per-generator: close in every other situation.
// - Closer is the largest rated power, lower address breaks ties.
// - Units failing to close or shut down are not closing candidates.
// - A unit stuck closed is sole closer until acknowledged.
// - Both warnings keep exactly one earthed unit in generator parallel.
// - Command output high closes the switch, low opens it.
// - Feedback high means the switch is closed.
`timescale 1ns/1ns
`default_nettype none

module nesc_top
    import nesc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_DEFAULT
) (
    // Clock, reset and enable.
    input  wire logic                        clk_in,
    input  wire logic                        reset_n_in,
    input  wire logic                        ce_in,
    // AHB-Lite slave.
    input  wire logic                        hsel_in,
    input  wire logic [31:0]                 haddr_in,
    input  wire logic [1:0]                  htrans_in,
    input  wire logic                        hwrite_in,
    input  wire logic [2:0]                  hsize_in,
    input  wire logic [31:0]                 hwdata_in,
    input  wire logic                        hready_in,
    output logic [31:0]                      hrdata_out,
    output logic                             hreadyout_out,
    output logic                             hresp_out,
    // Generator and mains status.
    input  wire logic                        engine_running_in,
    input  wire logic                        gen_voltage_ok_in,
    input  wire logic                        gen_frequency_ok_in,
    input  wire logic                        stop_sequence_in,
    input  wire logic                        shutdown_active_in,
    input  wire logic                        generator_breaker_closed_in,
    input  wire logic                        mains_breaker_closed_in,
    input  wire logic                        mains_group_breaker_closed_in,
    input  wire logic                        breaker_close_request_in,
    // Earthing switch pins.
    input  wire logic                        earth_switch_feedback_in,
    output logic                             earth_switch_command_out,
    output logic                             generator_breaker_close_out,
    // Warnings.
    output logic                             fail_close_warning_out,
    output logic                             fail_open_warning_out,
    output logic                             fail_close_alarm_out,
    // Peer units as seen on the power management bus.
    input  wire logic [NUM_PEERS-1:0]        peer_valid_in,
    input  wire logic [NUM_PEERS-1:0]        peer_breaker_closed_in,
    input  wire logic [NUM_PEERS-1:0]        peer_switch_closed_in,
    input  wire logic [NUM_PEERS-1:0]        peer_close_cmd_in,
    input  wire logic [NUM_PEERS-1:0]        peer_fail_close_in,
    input  wire logic [NUM_PEERS-1:0]        peer_fail_open_in,
    input  wire logic [NUM_PEERS-1:0]        peer_cannot_close_in,
    input  wire logic [NUM_PEERS*POWER_W-1:0] peer_power_in,
    input  wire logic [NUM_PEERS*ADDR_W-1:0] peer_address_in,
    // Own report for the power management bus.
    output logic                             bus_switch_closed_out,
    output logic                             bus_close_cmd_out,
    output logic                             bus_cannot_close_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [4:0]         ctrl;
        logic [15:0]        timeout;
        logic [15:0]        power;
        logic [7:0]         addr;
        logic               ph_valid;
        logic               ph_write;
        logic [7:0]         ph_addr;
        logic [31:0]        rdata;
        logic               ready;
        logic               resp;
        logic [15:0]        tick_cnt;
        logic               tick;
        nesc_seq_t          seq;
        logic [15:0]        lead_cnt;
        logic               brk_close;
        logic               cmd;
        logic               fb;
        logic               fail_close;
        logic               fail_open;
        logic               alarm;
        logic               cannot;
    } nesc_state_t;

    nesc_state_t st_q;
    nesc_state_t st_d;

    logic exp_close;
    logic exp_open;
    logic watch_close;
    logic watch_open;
    logic mains_par;
    logic any_gcb;
    logic peers_close;
    logic beaten;
    logic ok_volt;
    logic next_cmd;
    logic ack_wr;

    // Arbitration rank: stuck-closed first, then candidate, power, address.
    function automatic logic [RANK_W-1:0] nesc_rank(
        input logic               stuck,
        input logic               cand,
        input logic [POWER_W-1:0] pwr,
        input logic [ADDR_W-1:0]  adr
    );
        nesc_rank = {stuck, cand, pwr, ~adr};
    endfunction

    // Register read decode.
    function automatic logic [31:0] nesc_read(
        input nesc_state_t s,
        input logic [7:0]  a,
        input logic        mp
    );
        case (a)
            REG_CTRL:    nesc_read = {27'h000_0000, s.ctrl};
            REG_TIMEOUT: nesc_read = {16'h0000, s.timeout};
            REG_IDENT:   nesc_read = {8'h00, s.addr, s.power};
            REG_STATUS:  nesc_read = {26'h000_0000, mp, s.alarm,
                                      s.fail_open, s.fail_close,
                                      s.fb, s.cmd};
            default:     nesc_read = WORD_ZERO;
        endcase
    endfunction

    // ****************************************************************
    // Mismatch timer
    // ****************************************************************
    nesc_mismatch_timer u_timer (
        .clk_in           (clk_in),
        .reset_n_in       (reset_n_in),
        .ce_in            (ce_in),
        .tick_in          (st_q.tick),
        .cmd_in           (st_q.cmd),
        .fb_in            (st_q.fb),
        .watch_close_in   (watch_close),
        .watch_open_in    (watch_open),
        .timeout_in       (st_q.timeout),
        .expired_close_out(exp_close),
        .expired_open_out (exp_open)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Computes the command, arbitration, warnings and bus slave update.
    always_comb begin
        st_d = st_q;
        mains_par = generator_breaker_closed_in & mains_breaker_closed_in
                    & mains_group_breaker_closed_in;
        any_gcb = generator_breaker_closed_in
                  | (|(peer_valid_in & peer_breaker_closed_in));
        peers_close = |(peer_valid_in & peer_close_cmd_in);
        ok_volt = gen_voltage_ok_in & gen_frequency_ok_in;
        beaten = 1'b0;
        for (int i = 0; i < NUM_PEERS; i++) begin
            if (peer_valid_in[i] && peer_breaker_closed_in[i]
                && peer_switch_closed_in[i]
                && (nesc_rank(peer_fail_open_in[i],
                              !peer_fail_close_in[i]
                              && !peer_cannot_close_in[i],
                              peer_power_in[i*POWER_W +: POWER_W],
                              peer_address_in[i*ADDR_W +: ADDR_W])
                    > nesc_rank(st_q.fail_open,
                                !st_q.fail_close && !st_q.cannot,
                                st_q.power, st_q.addr))) begin
                beaten = 1'b1;
            end
        end
        // Millisecond tick.
        if (st_q.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            st_d.tick_cnt = CNT_ZERO;
            st_d.tick = 1'b1;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + CNT_ONE;
            st_d.tick = 1'b0;
        end
        // Breaker close sequence with earth switch lead.
        st_d.brk_close = 1'b0;
        case (st_q.seq)
            SEQ_IDLE: begin
                st_d.lead_cnt = CNT_ZERO;
                if (breaker_close_request_in) begin
                    if (st_q.ctrl[CTRL_COMPLETE] && st_q.ctrl[CTRL_SHARED]
                        && !any_gcb) begin
                        st_d.seq = SEQ_LEAD;
                    end else begin
                        st_d.seq = SEQ_CLOSE;
                        st_d.brk_close = 1'b1;
                    end
                end
            end
            SEQ_LEAD: begin
                if (!breaker_close_request_in) begin
                    st_d.seq = SEQ_IDLE;
                end else if (st_q.lead_cnt >= LEAD_MS) begin
                    st_d.seq = SEQ_CLOSE;
                    st_d.brk_close = 1'b1;
                end else if (st_q.tick) begin
                    st_d.lead_cnt = st_q.lead_cnt + CNT_ONE;
                end
            end
            SEQ_CLOSE: begin
                st_d.brk_close = breaker_close_request_in;
                if (!breaker_close_request_in) begin
                    st_d.seq = SEQ_IDLE;
                end
            end
            default: begin
                st_d.seq = SEQ_IDLE;
            end
        endcase
        // Earth switch command.
        if (!st_q.ctrl[CTRL_COMPLETE]) begin
            next_cmd = engine_running_in & ok_volt & !stop_sequence_in
                       & !mains_par;
        end else if (st_q.ctrl[CTRL_SHARED]) begin
            next_cmd = (generator_breaker_closed_in & !mains_par)
                       | (st_q.seq == SEQ_LEAD);
        end else if (!generator_breaker_closed_in) begin
            next_cmd = engine_running_in
                       & (ok_volt | st_q.ctrl[CTRL_COIL_AUX]);
        end else begin
            next_cmd = !mains_par && !beaten;
        end
        st_d.cmd = next_cmd;
        st_d.fb = earth_switch_feedback_in;
        st_d.cannot = shutdown_active_in;
        // Which mismatches are watched by the timer.
        if (!st_q.ctrl[CTRL_FB_EN] || !st_q.ctrl[CTRL_COMPLETE]) begin
            watch_close = 1'b0;
            watch_open = 1'b0;
        end else if (st_q.ctrl[CTRL_SHARED]) begin
            watch_close = any_gcb;
            watch_open = !peers_close;
        end else begin
            watch_close = 1'b1;
            watch_open = 1'b1;
        end
        // Bus slave: address phase capture and data phase.
        ack_wr = st_q.ph_valid && st_q.ph_write
                 && (st_q.ph_addr == REG_ACK) && hwdata_in[ACK_BIT];
        st_d.ready = 1'b1;
        st_d.resp = 1'b0;
        if (st_q.ph_valid && st_q.ph_write) begin
            case (st_q.ph_addr)
                REG_CTRL: begin
                    st_d.ctrl = hwdata_in[CTRL_W-1:0];
                end
                REG_TIMEOUT: begin
                    st_d.timeout = hwdata_in[15:0];
                end
                REG_IDENT: begin
                    st_d.power = hwdata_in[15:0];
                    st_d.addr = hwdata_in[23:16];
                end
                default: begin
                end
            endcase
        end
        st_d.ph_valid = hsel_in && hready_in
                        && ((htrans_in & HTRANS_NONSEQ_BIT) != 2'h0);
        st_d.ph_write = hwrite_in;
        st_d.ph_addr = haddr_in[7:0];
        st_d.rdata = st_d.ph_valid && !hwrite_in
                     ? nesc_read(st_q, haddr_in[7:0], mains_par) : WORD_ZERO;
        // Sticky warnings: a new event wins over an acknowledgement.
        if (ack_wr) begin
            st_d.fail_close = 1'b0;
            st_d.fail_open = 1'b0;
            st_d.alarm = 1'b0;
        end
        if (exp_close) begin
            st_d.fail_close = 1'b1;
            st_d.alarm = st_q.alarm | st_q.ctrl[CTRL_ESCALATE];
        end
        if (exp_open) begin
            st_d.fail_open = 1'b1;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Registers all state; the enable freezes everything while low.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= '{ctrl: CTRL_RST, timeout: TIMEOUT_RST,
                      power: POWER_RST, addr: ADDR_RST, ready: 1'b1,
                      seq: SEQ_IDLE, default: '0};
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flops.
    assign hrdata_out = st_q.rdata;
    assign hreadyout_out = st_q.ready;
    assign hresp_out = st_q.resp;
    assign earth_switch_command_out = st_q.cmd;
    assign generator_breaker_close_out = st_q.brk_close;
    assign fail_close_warning_out = st_q.fail_close;
    assign fail_open_warning_out = st_q.fail_open;
    assign fail_close_alarm_out = st_q.alarm;
    assign bus_switch_closed_out = st_q.fb;
    assign bus_close_cmd_out = st_q.cmd;
    assign bus_cannot_close_out = st_q.cannot;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_simple_close: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && !st_q.ctrl[CTRL_COMPLETE] && engine_running_in && ok_volt
        && !stop_sequence_in && !mains_par |=> earth_switch_command_out)
        else $error("simplified scheme did not close the switch");
    chk_simple_stop: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && !st_q.ctrl[CTRL_COMPLETE] && stop_sequence_in
        |=> !earth_switch_command_out)
        else $error("stop sequence left the switch closed");
    chk_mains_open: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && mains_par && st_q.seq != SEQ_LEAD
        |=> !earth_switch_command_out)
        else $error("switch closed during mains parallel");
    chk_shared_close: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && st_q.ctrl[CTRL_COMPLETE] && st_q.ctrl[CTRL_SHARED]
        && generator_breaker_closed_in && !mains_par
        |=> earth_switch_command_out)
        else $error("shared switch not commanded with breaker closed");
    chk_lead_before: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        $rose(generator_breaker_close_out) && $past(st_q.seq == SEQ_LEAD)
        |-> $past(earth_switch_command_out, 2))
        else $error("breaker closed before the earth switch lead");
    chk_close_suppress: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        st_q.ctrl[CTRL_SHARED] && !any_gcb |-> !watch_close)
        else $error("close failure watched with no breaker closed");
    chk_pergen_idle: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && st_q.ctrl[CTRL_COMPLETE] && !st_q.ctrl[CTRL_SHARED]
        && !generator_breaker_closed_in && !engine_running_in
        |=> !earth_switch_command_out)
        else $error("per-generator switch closed with engine stopped");
    chk_beaten_open: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && st_q.ctrl[CTRL_COMPLETE] && !st_q.ctrl[CTRL_SHARED]
        && generator_breaker_closed_in && beaten
        |=> !earth_switch_command_out)
        else $error("lower ranked unit kept its switch closed");
    chk_warn_escalate: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && exp_close && st_q.ctrl[CTRL_ESCALATE]
        |=> fail_close_alarm_out && fail_close_warning_out)
        else $error("close failure not escalated to alarm");

endmodule

`default_nettype wire

// ===== nesc_mismatch_timer.sv
// Command/feedback mismatch timer for the earthing switch.
// Assumes a one-cycle millisecond tick and a timeout in milliseconds.
`timescale 1ns/1ns
`default_nettype none

module nesc_mismatch_timer
    import nesc_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        ce_in,
    input  wire logic        tick_in,
    // Command, feedback and watch conditions.
    input  wire logic        cmd_in,
    input  wire logic        fb_in,
    input  wire logic        watch_close_in,
    input  wire logic        watch_open_in,
    input  wire logic [15:0] timeout_in,
    // Expiry levels.
    output logic             expired_close_out,
    output logic             expired_open_out
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        cmd_prev;
        logic        exp_c;
        logic        exp_o;
    } nesc_timer_t;

    nesc_timer_t tq;
    nesc_timer_t td;
    logic        mis_c;
    logic        mis_o;

    // Counts continuous disagreement; any change or agreement restarts it.
    always_comb begin
        td = tq;
        mis_c = cmd_in && !fb_in && watch_close_in;
        mis_o = !cmd_in && fb_in && watch_open_in;
        td.cmd_prev = cmd_in;
        if ((cmd_in != tq.cmd_prev) || !(mis_c || mis_o)) begin
            td.cnt = CNT_ZERO;
        end else if (tick_in && tq.cnt != CNT_MAX) begin
            td.cnt = tq.cnt + CNT_ONE;
        end
        td.exp_c = mis_c && (cmd_in == tq.cmd_prev)
                   && (tq.cnt >= timeout_in);
        td.exp_o = mis_o && (cmd_in == tq.cmd_prev)
                   && (tq.cnt >= timeout_in);
    end

    // Timer registers.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tq <= '0;
        end else if (ce_in) begin
            tq <= td;
        end
    end

    assign expired_close_out = tq.exp_c;
    assign expired_open_out = tq.exp_o;

    chk_timer_restart: assert property (@(posedge clk_in)
        disable iff (!reset_n_in)
        ce_in && (cmd_in != tq.cmd_prev) |=> tq.cnt == CNT_ZERO)
        else $error("mismatch timer not restarted on command change");

endmodule

`default_nettype wire

// ===== nesc_peer_model.sv
// Far-side model: the earthing contactor and one peer unit on the bus.
// Assumes the bench drives the stuck and peer controls after clock edges.
`timescale 1ns/1ns
`default_nettype none
module nesc_peer_model
    import nesc_pkg::*;
(
    // Clock and controls.
    input  wire logic                         clk_in,
    input  wire logic                         cmd_in,
    input  wire logic                         stuck_open_in,
    input  wire logic                         peer_on_in,
    // Contactor feedback and peer data.
    output logic                              fb_out,
    output logic [NUM_PEERS-1:0]              present_out,
    output logic [NUM_PEERS-1:0]              clear_out,
    output logic [NUM_PEERS*POWER_W-1:0]      power_out,
    output logic [NUM_PEERS*ADDR_W-1:0]       addr_out
);
    // Contact closes a cycle after the coil command unless stuck open.
    always_ff @(posedge clk_in) fb_out <= cmd_in & !stuck_open_in;
    // Peer 0 has breaker and switch closed and a larger rating.
    assign present_out = {6'h00, peer_on_in};
    assign clear_out   = 7'h00;
    assign power_out   = {96'h0, 16'hFFFF};
    assign addr_out    = {48'h0, 8'h02};
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the earth switch control over AHB-Lite.
// Assumes a zero-wait slave and a four-cycle millisecond tick.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import nesc_pkg::*;
    logic clk_in = 0, reset_n_in = 0, ce_in = 1, hsel_in = 0, hwrite_in = 0;
    logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, r;
    logic [1:0] htrans_in = 0;
    logic [2:0] hsize_in = 3'h2;
    logic engine_running_in = 0, gen_voltage_ok_in = 0, gen_frequency_ok_in = 0;
    logic stop_sequence_in = 0, shutdown_active_in = 0, breaker_close_request_in = 0;
    logic generator_breaker_closed_in = 0, mains_breaker_closed_in = 0;
    logic mains_group_breaker_closed_in = 0, stuck = 0, peer_on = 0;
    logic earth_switch_feedback_in, earth_switch_command_out, hreadyout_out;
    logic hresp_out, generator_breaker_close_out, fail_close_warning_out;
    logic fail_open_warning_out, fail_close_alarm_out, bus_switch_closed_out;
    logic bus_close_cmd_out, bus_cannot_close_out;
    logic [NUM_PEERS-1:0] pres, clr;
    logic [NUM_PEERS*POWER_W-1:0] pwr;
    logic [NUM_PEERS*ADDR_W-1:0] adr;
    wire hready_in = hreadyout_out;
    int errors = 0, checks_done = 0, n;
    always #10 clk_in = ~clk_in;
    nesc_top #(.TICK_CYCLES(4)) nesc_top_inst (.clk_in, .reset_n_in, .ce_in,
        .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
        .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .engine_running_in,
        .gen_voltage_ok_in, .gen_frequency_ok_in, .stop_sequence_in,
        .shutdown_active_in, .generator_breaker_closed_in, .mains_breaker_closed_in,
        .mains_group_breaker_closed_in, .breaker_close_request_in,
        .earth_switch_feedback_in, .earth_switch_command_out,
        .generator_breaker_close_out, .fail_close_warning_out,
        .fail_open_warning_out, .fail_close_alarm_out, .peer_valid_in(pres),
        .peer_breaker_closed_in(pres), .peer_switch_closed_in(pres),
        .peer_close_cmd_in(pres), .peer_fail_close_in(clr),
        .peer_fail_open_in(clr), .peer_cannot_close_in(clr),
        .peer_power_in(pwr), .peer_address_in(adr), .bus_switch_closed_out,
        .bus_close_cmd_out, .bus_cannot_close_out);
    nesc_peer_model nesc_peer_model_inst (.clk_in, .cmd_in(earth_switch_command_out),
        .stuck_open_in(stuck), .peer_on_in(peer_on), .fb_out(earth_switch_feedback_in),
        .present_out(pres), .clear_out(clr), .power_out(pwr), .addr_out(adr));
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits a bounded number of edges for the slave to be ready.
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin @(posedge clk_in); k++; end while (hready_in !== 1'b1 && k < 50);
        if (hready_in !== 1'b1) begin errors++; complete_run(); end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel_in <= 1; haddr_in <= {24'h0, a}; htrans_in <= 2'h2; hwrite_in <= w;
        wait_rdy();
        hsel_in <= 0; htrans_in <= 2'h0; hwdata_in <= d;
        wait_rdy();
        r = hrdata_out; chk(hresp_out, 0);
    endtask
    task automatic step(input int k); repeat (k) @(posedge clk_in); #1; endtask
    initial begin
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1;
        bus(0, REG_CTRL, 0); chk(r, 32'h0000_0000);
        bus(0, REG_TIMEOUT, 0); chk(r, 32'h0000_03E8);
        engine_running_in <= 1; gen_voltage_ok_in <= 1; gen_frequency_ok_in <= 1;
        step(2); chk(earth_switch_command_out, 1);
        generator_breaker_closed_in <= 1; mains_breaker_closed_in <= 1;
        mains_group_breaker_closed_in <= 1;
        step(2); chk(earth_switch_command_out, 0);
        mains_breaker_closed_in <= 0; step(2); chk(earth_switch_command_out, 1);
        stop_sequence_in <= 1; step(2); chk(earth_switch_command_out, 0);
        stop_sequence_in <= 0;
        bus(1, REG_TIMEOUT, 32'h0000_0002); bus(1, REG_CTRL, 32'h0000_0011);
        peer_on <= 1; step(3); chk(earth_switch_command_out, 0);
        peer_on <= 0; step(3); chk(earth_switch_command_out, 1);
        stuck <= 1;
        for (n = 0; n < 200 && fail_close_warning_out !== 1'b1; n++) step(1);
        chk(fail_close_warning_out, 1); chk(n > 8, 1);
        bus(0, REG_STATUS, 0); chk(r & 32'h0000_0004, 32'h0000_0004);
        stuck <= 0; step(2); bus(1, REG_ACK, 32'h0000_0001);
        step(2); chk(fail_close_warning_out, 0);
        generator_breaker_closed_in <= 0; engine_running_in <= 0;
        step(2); chk(earth_switch_command_out, 0);
        bus(1, REG_CTRL, 32'h0000_001B); breaker_close_request_in <= 1;
        step(3); chk(earth_switch_command_out, 1);
        for (n = 0; n < 400 && generator_breaker_close_out !== 1; n++) step(1);
        chk(n + 4 >= 4 * LEAD_MS, 1); chk(generator_breaker_close_out, 1);
        generator_breaker_closed_in <= 1; stuck <= 1;
        for (n = 0; n < 200 && fail_close_alarm_out !== 1; n++) step(1);
        chk(fail_close_alarm_out, 1);
        chk(earth_switch_command_out, 1);
        bus(0, 8'h20, 0); chk(r, 32'h0000_0000);
        complete_run();
    end
endmodule
`default_nettype wire
